// file: rtl/scaler_task_pkg.sv
package scaler_task_pkg;
    // Register offsets on the byte-wide register port
    localparam logic [7:0] TASK_A_CONTROL_ADDR       = 8'h90;
    localparam logic [7:0] EXT_SYNC_TRIGGER_SEL_ADDR = 8'h92;
    localparam logic [7:0] TASK_B_CONTROL_ADDR       = 8'hC0;
    localparam logic [7:0] GLOBAL_ENABLE_ADDR        = 8'h80;
    localparam logic [7:0] SOFT_RESET_ADDR           = 8'h88;

    // Task control field positions
    localparam int START_COND_LSB     = 0;
    localparam int REPEAT_BIT         = 2;
    localparam int SKIP_LSB           = 3;
    localparam int OUT_FID_SEL_BIT    = 6;
    localparam int CODE_BIT7_INV_BIT  = 7;
    // Trigger select field positions
    localparam int HORIZ_TRIG_BIT     = 2;
    localparam int VERT_TRIG_LO_BIT   = 4;
    localparam int VERT_TRIG_HI_BIT   = 5;
    localparam int FIELD_POL_BIT      = 6;
    localparam int FIELD_EDGE_BIT     = 7;
    // Global bits
    localparam int FIRST_EN_BIT       = 4;
    localparam int SECOND_EN_BIT      = 5;
    localparam int SOFT_RESET_BIT     = 5;

    // Reset values
    localparam logic [7:0] TASK_CTRL_RESET  = 8'h00;
    localparam logic [7:0] TRIG_SEL_RESET   = 8'h00;
    localparam logic [7:0] GLOBAL_EN_RESET  = 8'h00;
    localparam logic [7:0] SOFT_RESET_INIT  = 8'h20;

    // Earliest start lines
    localparam logic [11:0] DEC_LINE_F1_50 = 12'h0004;
    localparam logic [11:0] DEC_LINE_F1_60 = 12'h0007;
    localparam logic [11:0] DEC_LINE_F2_50 = 12'h0003;
    localparam logic [11:0] DEC_LINE_F2_60 = 12'h0006;
    localparam logic [11:0] DEC_LINE_DEF_50 = 12'h0002;
    localparam logic [11:0] DEC_LINE_DEF_60 = 12'h0005;
    localparam logic [11:0] EXT_LINE_50    = 12'h0017;
    localparam logic [11:0] EXT_LINE_60    = 12'h0014;

    // Start conditions
    localparam logic [1:0] START_NOW   = 2'h0;
    localparam logic [1:0] START_VSYNC = 2'h1;
    localparam logic [1:0] START_FID0  = 2'h2;
    localparam logic [1:0] START_FID1  = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT_V, ST_SKIP, ST_WAIT_OFS, ST_RUN
    } task_state_t;
endpackage

// file: rtl/field_detect.sv
// Field identifier capture from the selected sync source
module field_detect
    import scaler_task_pkg::*;
(
    input  wire logic clk_i,            // Clock
    input  wire logic rst_i,            // Synchronous reset
    input  wire logic ext_src_i,        // External stream selected
    input  wire logic ext_vref_i,       // External vertical reference
    input  wire logic ext_decoder_line_reference_i,       // External horizontal reference
    input  wire logic dec_fid_i,        // Decoder field identifier
    input  wire logic edge_sel_i,       // 1 = rising vertical edge
    input  wire logic polarity_i,       // Invert detected identifier
    output logic      fid_o,            // Field identifier
    output logic      vsync_o           // Vertical event pulse
);
    logic vref_d_reg;
    logic fid_reg;
    logic ext_fid_raw;

    // Edge of the external vertical reference
    wire rise_w = ext_vref_i & ~vref_d_reg;
    wire fall_w = ~ext_vref_i & vref_d_reg;
    wire vedge_w = edge_sel_i ? rise_w : fall_w;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vref_d_reg <= 1'b0;
            ext_fid_raw <= 1'b0;
        end else begin
            vref_d_reg <= ext_vref_i;
            if (vedge_w) begin
                ext_fid_raw <= ext_decoder_line_reference_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fid_reg <= 1'b0;
        end else begin
            fid_reg <= (ext_src_i ? ext_fid_raw : dec_fid_i) ^ polarity_i;
        end
    end

    assign fid_o   = fid_reg;
    assign vsync_o = vedge_w;
endmodule // field_detect

// file: rtl/scaler_task_handler.sv
module scaler_task_handler
    import scaler_task_pkg::*;
// Function
// - Decoder trigger: start lines 4/7, 3/6
// - Default decoder trigger: start line 2/5
// - External stream: start line 23/20
// - Two tasks, each gated by enable
// - Soft reset forces idle immediately
// - Enable changes apply at task end
// - Four selectable start conditions
// - Field check only after offsets reached
// - Repeat bit reruns current task once
// - Skip programmed fields before task
// - Toggle flag inverts per task activation
// - Past offsets means wait next vsync
// - Triggers checked only for active task
// - Second task first after reset
// - Output field select 0: input identifier
// - Output field select 1: toggle flag
// - Code bit 7 set or inverted
// - Toggle not synchronised to input field
// - External identifier sampled at vertical edge
// - Identifier 0 first field; polarity invert
(
    input  wire logic        clk_i,          // Clock
    input  wire logic        rst_i,          // Synchronous reset
    input  wire logic        reg_wr_i,       // Register write strobe
    input  wire logic [7:0]  reg_addr_i,     // Register address
    input  wire logic [7:0]  reg_wdata_i,    // Register write data
    output logic      [7:0]  reg_rdata_o,    // Register read data
    input  wire logic        ext_src_i,      // External stream source
    input  wire logic        sys60_i,        // 60 Hz system
    input  wire logic        dec_vpulse_i,   // Decoder vertical pulse
    input  wire logic        dec_decoder_line_reference_i,     // Decoder line reference
    input  wire logic        dec_fid_i,      // Decoder field identifier
    input  wire logic        ext_vref_i,     // External vertical reference
    input  wire logic        ext_decoder_line_reference_i,     // External horizontal reference
    input  wire logic        ext_sav_i,      // External start of video code
    input  wire logic        offset_hit_i,   // Both offsets reached
    input  wire logic        offset_past_i,  // Position beyond offsets
    input  wire logic        task_done_i,    // Current task window ended
    output logic             active_o,       // Task running, data emitted
    output logic             task_b_o,       // Running task is second
    output logic             code_d6_o,      // Code bit D6
    output logic             code_d7_o,      // Code bit D7
    output logic             toggle_o,       // Running task toggle
    output logic             fid_o           // Detected field identifier
);
    logic [7:0]  ctrl_a_reg;
    logic [7:0]  ctrl_b_reg;
    logic [7:0]  trig_reg;
    logic [7:0]  glob_reg;
    logic [7:0]  soft_reset_bit_reg;
    logic [7:0]  rdata_reg;
    task_state_t state_reg;
    logic        cur_b_reg;
    logic        en_a_reg;
    logic        en_b_reg;
    logic        rep_done_reg;
    logic [2:0]  skip_reg;
    logic [1:0]  toggle_reg;
    logic [11:0] line_reg;
    logic        vpulse_d_reg;
    logic        decoder_line_reference_d_reg;
    logic        armed_reg;
    logic        active_reg;
    logic        d6_reg;
    logic        d7_reg;
    logic        fid_w;
    logic        ext_v_w;

    field_detect u_field_detect (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ext_src_i  (ext_src_i),
        .ext_vref_i (ext_vref_i),
        .ext_decoder_line_reference_i (ext_decoder_line_reference_i),
        .dec_fid_i  (dec_fid_i),
        .edge_sel_i (trig_reg[FIELD_EDGE_BIT]),
        .polarity_i (trig_reg[FIELD_POL_BIT]),
        .fid_o      (fid_w),
        .vsync_o    (ext_v_w)
    );

    // Decode of register port
    wire wr_a_w    = reg_wr_i && (reg_addr_i == TASK_A_CONTROL_ADDR);
    wire wr_b_w    = reg_wr_i && (reg_addr_i == TASK_B_CONTROL_ADDR);
    wire wr_trig_w = reg_wr_i && (reg_addr_i == EXT_SYNC_TRIGGER_SEL_ADDR);
    wire wr_glob_w = reg_wr_i && (reg_addr_i == GLOBAL_ENABLE_ADDR);
    wire wr_sw_w   = reg_wr_i && (reg_addr_i == SOFT_RESET_ADDR);
    wire soft_w    = ~soft_reset_bit_reg[SOFT_RESET_BIT];

    // Current task control fields
    wire [7:0] cur_ctrl_w  = cur_b_reg ? ctrl_b_reg : ctrl_a_reg;
    wire [1:0] start_w     = cur_ctrl_w[START_COND_LSB +: 2];
    wire       repeat_w    = cur_ctrl_w[REPEAT_BIT];
    wire [2:0] skip_cfg_w  = cur_ctrl_w[SKIP_LSB +: 3];
    wire       cur_en_w    = cur_b_reg ? en_b_reg : en_a_reg;
    wire       other_en_w  = cur_b_reg ? en_a_reg : en_b_reg;
    wire       cur_tog_w   = toggle_reg[cur_b_reg];

    // Sync edges from decoder, or from the external stream when selected
    wire dec_v_fall_w = ~dec_vpulse_i & vpulse_d_reg;
    wire decoder_line_reference_rise_w  = dec_decoder_line_reference_i & ~decoder_line_reference_d_reg;
    wire vsync_w      = ext_src_i ? ext_v_w : dec_v_fall_w;
    wire line_ev_w    = ext_src_i ? ext_sav_i : decoder_line_reference_rise_w;

    wire [11:0] alt_line_w = fid_w ? (sys60_i ? DEC_LINE_F2_60 : DEC_LINE_F2_50)
                                   : (sys60_i ? DEC_LINE_F1_60 : DEC_LINE_F1_50);
    wire [11:0] def_line_w = sys60_i ? DEC_LINE_DEF_60 : DEC_LINE_DEF_50;
    wire [11:0] ext_line_w = sys60_i ? EXT_LINE_60 : EXT_LINE_50;
    wire        alt_trig_w = trig_reg[VERT_TRIG_LO_BIT] & ~trig_reg[VERT_TRIG_HI_BIT];
    wire [11:0] min_line_w = ext_src_i ? ext_line_w : (alt_trig_w ? alt_line_w : def_line_w);
    wire        start_ok_w = armed_reg && line_ev_w && (line_reg >= min_line_w);

    wire fid_ok_w = (start_w == START_FID0) ? ~fid_w :
                    (start_w == START_FID1) ?  fid_w : 1'b1;
    wire go_w = start_ok_w && offset_hit_i && fid_ok_w;

    // Register write storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_a_reg <= TASK_CTRL_RESET;
            ctrl_b_reg <= TASK_CTRL_RESET;
            trig_reg   <= TRIG_SEL_RESET;
            glob_reg   <= GLOBAL_EN_RESET;
            soft_reset_bit_reg  <= SOFT_RESET_INIT;
        end else begin
            if (wr_a_w) ctrl_a_reg <= reg_wdata_i;
            if (wr_b_w) ctrl_b_reg <= reg_wdata_i;
            if (wr_trig_w) trig_reg <= reg_wdata_i;
            if (wr_glob_w) glob_reg <= reg_wdata_i;
            if (wr_sw_w) soft_reset_bit_reg <= reg_wdata_i;
        end
    end

    // Read multiplexer, unmapped reads zero
    wire [7:0] rd_w = (reg_addr_i == TASK_A_CONTROL_ADDR) ? ctrl_a_reg :
                      (reg_addr_i == TASK_B_CONTROL_ADDR) ? ctrl_b_reg :
                      (reg_addr_i == EXT_SYNC_TRIGGER_SEL_ADDR) ? trig_reg :
                      (reg_addr_i == GLOBAL_ENABLE_ADDR) ? glob_reg :
                      (reg_addr_i == SOFT_RESET_ADDR) ? soft_reset_bit_reg : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) rdata_reg <= 8'h00;
        else rdata_reg <= rd_w;
    end

    // Line counter and sync edge history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vpulse_d_reg <= 1'b0;
            decoder_line_reference_d_reg   <= 1'b0;
            line_reg     <= 12'h000;
            armed_reg    <= 1'b0;
        end else begin
            vpulse_d_reg <= dec_vpulse_i;
            decoder_line_reference_d_reg   <= dec_decoder_line_reference_i;
            // Lines counted from 1: the first line event after the
            // vertical event is line 1, so start lines compare directly
            if (vsync_w) begin
                line_reg  <= 12'h001;
                armed_reg <= 1'b1;
            end else if (line_ev_w) begin
                line_reg <= line_reg + 12'h001;
            end
        end
    end

    // Task state machine
    always_ff @(posedge clk_i) begin
        if (rst_i || soft_w) begin
            state_reg    <= ST_IDLE;
            cur_b_reg    <= 1'b1;
            en_a_reg     <= 1'b0;
            en_b_reg     <= 1'b0;
            rep_done_reg <= 1'b0;
            skip_reg     <= 3'h0;
            toggle_reg   <= 2'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    en_a_reg <= glob_reg[FIRST_EN_BIT];
                    en_b_reg <= glob_reg[SECOND_EN_BIT];
                    if (glob_reg[SECOND_EN_BIT]) begin
                        cur_b_reg <= 1'b1;
                        state_reg <= ST_WAIT_V;
                    end else if (glob_reg[FIRST_EN_BIT]) begin
                        cur_b_reg <= 1'b0;
                        state_reg <= ST_WAIT_V;
                    end
                    skip_reg <= 3'h0;
                end
                ST_WAIT_V: begin
                    if (start_w == START_NOW && !offset_past_i) begin
                        state_reg <= ST_SKIP;
                    end else if (vsync_w) begin
                        state_reg <= ST_SKIP;
                    end
                end
                ST_SKIP: begin
                    if (skip_reg == skip_cfg_w) begin
                        state_reg <= ST_WAIT_OFS;
                    end else if (vsync_w) begin
                        skip_reg <= skip_reg + 3'h1;
                    end
                end
                ST_WAIT_OFS: begin
                    if (go_w) begin
                        state_reg <= ST_RUN;
                        toggle_reg[cur_b_reg] <= ~cur_tog_w;
                    end else if (offset_past_i && !offset_hit_i) begin
                        state_reg <= ST_WAIT_V;
                    end
                end
                ST_RUN: begin
                    if (task_done_i) begin
                        skip_reg  <= 3'h0;
                        state_reg <= ST_WAIT_V;
                        en_a_reg  <= glob_reg[FIRST_EN_BIT];
                        en_b_reg  <= glob_reg[SECOND_EN_BIT];
                        if (repeat_w && !rep_done_reg && cur_en_w) begin
                            rep_done_reg <= 1'b1;
                        end else begin
                            rep_done_reg <= 1'b0;
                            if (other_en_w) cur_b_reg <= ~cur_b_reg;
                            else if (!cur_en_w) state_reg <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Output markers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_reg <= 1'b0;
            d6_reg     <= 1'b0;
            d7_reg     <= 1'b1;
        end else begin
            active_reg <= (state_reg == ST_RUN);
            d6_reg <= cur_ctrl_w[OUT_FID_SEL_BIT] ? cur_tog_w : fid_w;
            d7_reg <= ~cur_ctrl_w[CODE_BIT7_INV_BIT];
        end
    end

    logic tog_out_reg;
    logic task_b_reg;
    logic fid_out_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tog_out_reg <= 1'b0;
            task_b_reg  <= 1'b0;
            fid_out_reg <= 1'b0;
        end else begin
            tog_out_reg <= cur_tog_w;
            task_b_reg  <= cur_b_reg;
            fid_out_reg <= fid_w;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign active_o    = active_reg;
    assign task_b_o    = task_b_reg;
    assign code_d6_o   = d6_reg;
    assign code_d7_o   = d7_reg;
    assign toggle_o    = tog_out_reg;
    assign fid_o       = fid_out_reg;

    // Soft reset reaches idle next cycle
    AST_SOFT_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
        soft_w |=> (state_reg == ST_IDLE))
        else $error("soft reset did not idle");
    // Run only follows offset wait
    AST_RUN_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i || soft_w)
        (state_reg == ST_RUN) && ($past(state_reg) != ST_RUN)
        |-> $past(state_reg) == ST_WAIT_OFS)
        else $error("run entered without offsets");
    // Toggle flips on activation
    AST_TOGGLE: assert property (@(posedge clk_i) disable iff (rst_i || soft_w)
        (state_reg == ST_WAIT_OFS) && go_w |=> toggle_reg[cur_b_reg] != $past(cur_tog_w))
        else $error("toggle did not invert");
    // Active output follows run state
    AST_ACTIVE: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == ST_RUN) |=> active_o)
        else $error("active missing");
    // Field identifier filter, both polarities of the wait
    AST_FID0: assert property (@(posedge clk_i) disable iff (rst_i || soft_w)
        (state_reg == ST_WAIT_OFS) &&
        (((start_w == START_FID0) && fid_w) || ((start_w == START_FID1) && !fid_w))
        |=> state_reg != ST_RUN)
        else $error("started on wrong field");
    // Bit 7 from control
    AST_D7: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> code_d7_o == ~$past(cur_ctrl_w[CODE_BIT7_INV_BIT]))
        else $error("bit 7 wrong");
    // Bit 6 selection
    AST_D6: assert property (@(posedge clk_i) disable iff (rst_i)
        !cur_ctrl_w[OUT_FID_SEL_BIT] |=> code_d6_o == $past(fid_w))
        else $error("bit 6 wrong");
    // Earliest start line respected at run entry
    AST_MIN_LINE: assert property (@(posedge clk_i) disable iff (rst_i || soft_w)
        (state_reg == ST_RUN) && ($past(state_reg) == ST_WAIT_OFS)
        |-> $past(line_reg) >= $past(min_line_w))
        else $error("start too early");
    // A task only starts while it is enabled
    AST_EN_GATE: assert property (@(posedge clk_i) disable iff (rst_i || soft_w)
        (state_reg == ST_RUN) && ($past(state_reg) != ST_RUN) |-> $past(cur_en_w))
        else $error("disabled task started");
    // Second task chosen first out of idle
    AST_TASK_PICK: assert property (@(posedge clk_i) disable iff (rst_i || soft_w)
        (state_reg == ST_IDLE) && glob_reg[SECOND_EN_BIT]
        |=> cur_b_reg && (state_reg == ST_WAIT_V))
        else $error("second task not first");
    // Pending repeat keeps the same task
    AST_REPEAT: assert property (@(posedge clk_i) disable iff (rst_i || soft_w)
        (state_reg == ST_RUN) && task_done_i && repeat_w && !rep_done_reg && cur_en_w
        |=> cur_b_reg == $past(cur_b_reg))
        else $error("repeat handed over");
endmodule // scaler_task_handler

// file: dv/capture_model.sv
// Back-end capture side: counts scaled fields handed over
module capture_model (
    input  wire logic clk_i,     // Clock
    input  wire logic rst_i,     // Synchronous reset
    input  wire logic active_i,  // Task running, data emitted
    input  wire logic d6_i,      // Code bit D6
    input  wire logic d7_i,      // Code bit D7
    output int        starts_o,  // Captured field count
    output logic [1:0] codes_o   // Codes of last captured field
);
    timeunit 1ns;
    timeprecision 100ps;
    logic active_reg;

    // Count each rising edge of the data-valid marker
    always_ff @(posedge clk_i) begin
        active_reg <= rst_i ? 1'b0 : active_i;
        if (rst_i) begin
            starts_o <= 0;
            codes_o  <= 2'h0;
        end else if (active_i && !active_reg) begin
            starts_o <= starts_o + 1;
            codes_o  <= {d7_i, d6_i};
        end
    end
endmodule // capture_model

// file: dv/scaler_task_handler_tb_top.sv
module scaler_task_handler_tb_top
    import scaler_task_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_i = 0, rst_i = 1, reg_wr_i = 0, ext_src_i = 0, sys60_i = 0;
    logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
    logic       dec_vpulse_i = 0, dec_decoder_line_reference_i = 0, dec_fid_i = 0, ext_vref_i = 0;
    logic       ext_decoder_line_reference_i = 0, ext_sav_i = 0, offset_hit_i = 1, offset_past_i = 0;
    logic       task_done_i = 0, active_o, task_b_o, code_d6_o, code_d7_o, toggle_o, fid_o;
    logic [1:0] cap_codes;
    int         mismatches = 0, checks_done = 0, cycles = 0, exp_starts = 0, starts;

    always #2 clk_i = ~clk_i;

    scaler_task_handler dut (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .ext_src_i(ext_src_i), .sys60_i(sys60_i), .dec_vpulse_i(dec_vpulse_i),
        .dec_decoder_line_reference_i(dec_decoder_line_reference_i), .dec_fid_i(dec_fid_i), .ext_vref_i(ext_vref_i),
        .ext_decoder_line_reference_i(ext_decoder_line_reference_i), .ext_sav_i(ext_sav_i), .offset_hit_i(offset_hit_i),
        .offset_past_i(offset_past_i), .task_done_i(task_done_i), .active_o(active_o),
        .task_b_o(task_b_o), .code_d6_o(code_d6_o), .code_d7_o(code_d7_o),
        .toggle_o(toggle_o), .fid_o(fid_o));

    capture_model partner (.clk_i(clk_i), .rst_i(rst_i), .active_i(active_o),
        .d6_i(code_d6_o), .d7_i(code_d7_o), .starts_o(starts), .codes_o(cap_codes));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_int(input string nm, input int e, input int g);
        checks_done++;
        if (g != e) begin
            mismatches++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i  = a;
        reg_wdata_i = d;
        reg_wr_i    = 1;
        tick(1);
        reg_wr_i    = 0;
        tick(1);
    endtask

    // Reprogram with the scaler held idle, as software must
    task automatic setup(input logic [7:0] trig, en, a_ctl, b_ctl);
        wr(SOFT_RESET_ADDR, 8'h00);
        wr(EXT_SYNC_TRIGGER_SEL_ADDR, trig);
        wr(GLOBAL_ENABLE_ADDR, en);
        wr(TASK_A_CONTROL_ADDR, a_ctl);
        wr(TASK_B_CONTROL_ADDR, b_ctl);
        wr(SOFT_RESET_ADDR, SOFT_RESET_INIT);
    endtask

    // One field: vertical event, then line events until data starts
    task automatic field(input logic field_identifier, output int n);
        if (ext_src_i) begin
            ext_decoder_line_reference_i = field_identifier;
            ext_vref_i = 1;
            tick(2);
            ext_vref_i = 0;
        end else begin
            dec_fid_i    = field_identifier;
            dec_vpulse_i = 1;
            tick(2);
            dec_vpulse_i = 0;
        end
        tick(4);
        n = 0;
        while (n < 30 && active_o !== 1'b1) begin
            n++;
            ext_sav_i  = ext_src_i;
            dec_decoder_line_reference_i = !ext_src_i;
            tick(1);
            ext_sav_i  = 0;
            dec_decoder_line_reference_i = 0;
            tick(4);
        end
    endtask

    // Field with expected start line and markers; en of 30 means no start
    task automatic step(input logic field_identifier, input int en, input logic eb, et, e6, e7);
        int n;
        field(field_identifier, n);
        chk_int("start line", en, n);
        if (en == 30) begin
            chk_bit("active_o skipped", 1'b0, active_o);
        end else begin
            exp_starts++;
            chk_bit("task_b_o", eb, task_b_o);
            chk_bit("toggle_o", et, toggle_o);
            chk_bit("code_d6_o", e6, code_d6_o);
            chk_bit("code_d7_o", e7, code_d7_o);
            chk_byte("captured codes", {6'h00, e7, e6}, {6'h00, cap_codes});
        end
    endtask

    task automatic finish_task();
        task_done_i = 1;
        tick(1);
        task_done_i = 0;
        tick(3);
        chk_bit("active_o after end", 1'b0, active_o);
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        reg_addr_i = a;
        tick(2);
        chk_byte("reg_rdata_o", e, reg_rdata_o);
    endtask

    task automatic test_reset();
        chk_bit("code_d7_o idle", 1'b1, code_d7_o);
        chk_bit("active_o idle", 1'b0, active_o);
        chk_reg(TASK_A_CONTROL_ADDR, TASK_CTRL_RESET);
        chk_reg(TASK_B_CONTROL_ADDR, TASK_CTRL_RESET);
        chk_reg(EXT_SYNC_TRIGGER_SEL_ADDR, TRIG_SEL_RESET);
        chk_reg(GLOBAL_ENABLE_ADDR, GLOBAL_EN_RESET);
        chk_reg(SOFT_RESET_ADDR, SOFT_RESET_INIT);
        chk_reg(8'h55, 8'h00);
        $display("test reset done");
    endtask

    // Both tasks, B repeats, A waits for identifier 0, soft reset mid-task
    task automatic test_alternate();
        setup(8'h00, 8'h30, 8'h42, 8'hC4);
        step(0, 2, 1, 1, 1, 0);
        finish_task();
        step(1, 2, 1, 0, 0, 0);
        finish_task();
        step(0, 2, 0, 1, 1, 1);
        finish_task();
        step(1, 2, 1, 1, 1, 0);
        wr(SOFT_RESET_ADDR, 8'h00);
        tick(1);
        chk_bit("active_o soft reset", 1'b0, active_o);
        wr(SOFT_RESET_ADDR, SOFT_RESET_INIT);
        step(0, 2, 1, 1, 1, 0);
        finish_task();
        // Position beyond the offsets: no start until they are met again
        offset_hit_i  = 0;
        offset_past_i = 1;
        step(0, 30, 1, 0, 0, 0);
        offset_hit_i  = 1;
        offset_past_i = 0;
        step(1, 2, 1, 0, 0, 0);
        finish_task();
        $display("test alternate done");
    endtask

    // Task A alone on vertical sync, one field skipped, decoder trigger lines
    task automatic test_skip();
        setup(8'h10, 8'h10, 8'h09, 8'h00);
        step(0, 30, 0, 0, 0, 0);
        step(1, 3, 0, 1, 1, 1);
        finish_task();
        step(0, 30, 0, 0, 0, 0);
        step(0, 4, 0, 0, 0, 1);
        finish_task();
        $display("test skip done");
    endtask

    // External stream at 60 Hz, start on identifier 1, polarity flip
    task automatic test_external();
        ext_src_i = 1;
        sys60_i   = 1;
        setup(8'h00, 8'h10, 8'h03, 8'h00);
        step(0, 30, 0, 0, 0, 0);
        step(1, 20, 0, 1, 1, 1);
        chk_bit("fid_o", 1'b1, fid_o);
        finish_task();
        wr(EXT_SYNC_TRIGGER_SEL_ADDR, 8'h40);
        step(0, 20, 0, 0, 1, 1);
        chk_bit("fid_o inverted", 1'b1, fid_o);
        finish_task();
        $display("test external done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        tick(20);
        rst_i = 0;
        tick(2);
        test_reset();
        test_alternate();
        test_skip();
        test_external();
        chk_int("captured fields", exp_starts, starts);
        wrap_up();
    end
endmodule // scaler_task_handler_tb_top
